// >>> verilog/vfh_pkg.sv
package vfh_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] VFH_ADDR_CTRL   = 12'h000;   // control bits
   localparam logic [11:0] VFH_ADDR_STATUS = 12'h004;   // decision counters

   // control field positions
   localparam int VFH_BIT_TAG_KEEP   = 0;
   localparam int VFH_BIT_TRUNK_BYP  = 1;
   localparam int VFH_BIT_DROP_INV   = 2;
   localparam int VFH_BIT_FFF_FWD    = 3;
   localparam int VFH_BIT_CRC_BYP    = 4;
   localparam int VFH_BIT_DOUBLE_TAG = 5;
   localparam int VFH_CTRL_W         = 6;

   localparam logic [VFH_CTRL_W-1:0] VFH_CTRL_RESET = 6'h00;

   // ----------------------------------------------------------------
   // frame constants
   // ----------------------------------------------------------------
   localparam logic [11:0] VFH_VID_RESERVED = 12'hFFF;
   localparam int          VFH_PORTS        = 8;
   localparam int          VFH_CNT_W        = 16;
   localparam logic [VFH_CNT_W-1:0] VFH_CNT_ONE = 16'h0001;

   // frame descriptor handed to the decision logic
   typedef struct packed {
      logic [11:0]          vlan_identifier;
      logic                 has_tag;        // 802.1Q tag with nonzero id
      logic                 prio_only;      // priority-only tag
      logic                 from_mgmt;      // received on management port
      logic                 from_cpu;       // issued by cpu_management_port
      logic                 egress_directed;
      logic                 crc_ok;
      logic [2:0]           dest_port;
   } vfh_frame_type;

   // per-frame verdict
   typedef struct packed {
      logic                 drop;
      logic                 to_cpu;
      logic                 trunk_check;
      logic                 keep_tag_state;
      logic [VFH_PORTS-1:0] untag_map;
      logic [2:0]           dest_port;
   } vfh_verdict_type;

   // vlan table lookup answer
   typedef struct packed {
      logic                 hit;
      logic [VFH_PORTS-1:0] untag_map;
   } vfh_lookup_type;

endpackage : vfh_pkg

// >>> verilog/vfh_apb_regs.sv
`timescale 1ns/1ps
module vfh_apb_regs
   import vfh_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [31:0]           status_word,
   output logic      [VFH_CTRL_W-1:0] ctrl
);

   logic [VFH_CTRL_W-1:0] ctrl_q;
   logic                  access;

   assign access  = psel & penable;
   assign pready  = 1'b1;   // zero wait states
   assign ctrl    = ctrl_q;

   // --------------------------------------------------------------
   // control register write
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= VFH_CTRL_RESET;
      end else if (access && pwrite && paddr == VFH_ADDR_CTRL) begin
         ctrl_q <= pwdata[VFH_CTRL_W-1:0];
      end
   end

   // --------------------------------------------------------------
   // read mux and unmapped error
   // --------------------------------------------------------------
   always_comb begin
      prdata  = 32'h0000_0000;
      pslverr = 1'b0;
      if (access) begin
         case (paddr)
            VFH_ADDR_CTRL: begin
               prdata = {{(32-VFH_CTRL_W){1'b0}}, ctrl_q};
            end
            VFH_ADDR_STATUS: begin
               if (pwrite) begin
                  pslverr = 1'b1;   // read-only
               end else begin
                  prdata = status_word;
               end
            end
            default: begin
               pslverr = 1'b1;
            end
         endcase
      end
   end

endmodule : vfh_apb_regs

// >>> verilog/vfh_vlan_table.sv
`timescale 1ns/1ps
module vfh_vlan_table
   import vfh_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 wr_en,
   input  wire logic [11:0]          wr_vid,
   input  wire logic                 wr_valid,
   input  wire logic [VFH_PORTS-1:0] wr_untag,
   input  wire logic [11:0]          rd_vid,
   output vfh_lookup_type            rd_ans
);

   // ----------------------------------------------------------------
   // 4K entry table: valid bits reset, untag maps do not need to
   // ----------------------------------------------------------------
   logic [4095:0]        valid_q;
   logic [VFH_PORTS-1:0] untag_mem [0:4095];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         valid_q <= '0;
      end else if (wr_en) begin
         valid_q[wr_vid] <= wr_valid;
      end
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         untag_mem[wr_vid] <= wr_untag;
      end
   end

   // missing entry means invalid id
   assign rd_ans.hit       = valid_q[rd_vid];   // RULE9
   // missing or cleared entries hand over an empty map, never stale data
   assign rd_ans.untag_map = valid_q[rd_vid] ? untag_mem[rd_vid] : '0;

endmodule : vfh_vlan_table

// >>> verilog/vfh_ctrl.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
// Functional notes
// RULE1: reserved id FFF forwarded if enabled, else dropped
// RULE2: CRC check skipped on management port when bypassed
// RULE3: untagged frames leave unchanged when preserving
// RULE4: preservation ignored in double-tag operation
// RULE5: bypass disables trunk check for cpu frames
// RULE6: otherwise cpu directed frames get trunk checking
// RULE7: invalid id frames discarded when drop set
// RULE8: invalid id frames sent to cpu otherwise
// RULE9: invalid id means no table entry
// RULE10: software writes reserved bits as default
// RULE11: untag map governs egress tagging otherwise
module vfh_ctrl
   import vfh_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // vlan table fill
   input  wire logic                 tbl_wr_en,
   input  wire logic [11:0]          tbl_wr_vid,
   input  wire logic                 tbl_wr_valid,
   input  wire logic [VFH_PORTS-1:0] tbl_wr_untag,
   // frame in, verdict out
   input  wire logic                 frame_valid,
   input  wire vfh_frame_type        frame_in,
   output logic                      verdict_valid,
   output vfh_verdict_type           verdict
);

   typedef enum logic [1:0] {
      VFH_IDLE = 2'b01,
      VFH_EVAL = 2'b10
   } vfh_state_type;

   vfh_state_type         state_q;
   vfh_frame_type         frame_q;
   vfh_lookup_type        lookup;
   vfh_verdict_type       verdict_d;
   vfh_verdict_type       verdict_q;
   logic                  verdict_valid_q;
   logic [VFH_CTRL_W-1:0] ctrl;
   logic [VFH_CNT_W-1:0]  drop_cnt_q;
   logic [VFH_CNT_W-1:0]  cpu_cnt_q;
   logic                  keep_en;

   // ----------------------------------------------------------------
   // register bank
   // ----------------------------------------------------------------
   // reserved bits above the control field read back as zero
   vfh_apb_regs u_regs (
      .clk         (clk),
      .arst_n      (arst_n),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .status_word ({cpu_cnt_q, drop_cnt_q}),
      .ctrl        (ctrl)
   );

   // ----------------------------------------------------------------
   // vlan table
   // ----------------------------------------------------------------
   vfh_vlan_table u_table (
      .clk      (clk),
      .arst_n   (arst_n),
      .wr_en    (tbl_wr_en),
      .wr_vid   (tbl_wr_vid),
      .wr_valid (tbl_wr_valid),
      .wr_untag (tbl_wr_untag),
      .rd_vid   (frame_q.vlan_identifier),
      .rd_ans   (lookup)
   );

   // ----------------------------------------------------------------
   // frame capture and state
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= VFH_IDLE;
         frame_q <= '0;
      end else begin
         case (state_q)
            VFH_IDLE: begin
               if (frame_valid) begin
                  frame_q <= frame_in;
                  state_q <= VFH_EVAL;
               end
            end
            VFH_EVAL: begin
               state_q <= VFH_IDLE;
            end
            default: begin
               state_q <= VFH_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // decision logic
   // ----------------------------------------------------------------
   // preservation has no effect in double-tag operation
   assign keep_en = ctrl[VFH_BIT_TAG_KEEP] & ~ctrl[VFH_BIT_DOUBLE_TAG];   // RULE4

   always_comb begin
      verdict_d           = '0;
      verdict_d.dest_port = frame_q.dest_port;
      verdict_d.untag_map = lookup.untag_map;   // RULE11
      // untagged or priority-only frames keep their tag state
      if (keep_en && (!frame_q.has_tag || frame_q.prio_only)) begin
         verdict_d.keep_tag_state = 1'b1;   // RULE3
      end
      // cpu-issued directed frames: trunk check unless bypassed
      if (frame_q.from_cpu && frame_q.egress_directed) begin
         verdict_d.trunk_check = ~ctrl[VFH_BIT_TRUNK_BYP];   // RULE5 RULE6
      end else begin
         verdict_d.trunk_check = 1'b1;
      end
      // crc check on management port unless bypassed
      if (!frame_q.crc_ok && !(frame_q.from_mgmt && ctrl[VFH_BIT_CRC_BYP])) begin
         verdict_d.drop = 1'b1;   // RULE2
      end else if (frame_q.has_tag && frame_q.vlan_identifier == VFH_VID_RESERVED) begin
         verdict_d.drop = ~ctrl[VFH_BIT_FFF_FWD];   // RULE1
      end else if (frame_q.has_tag && !lookup.hit) begin
         if (ctrl[VFH_BIT_DROP_INV]) begin
            verdict_d.drop = 1'b1;   // RULE7
         end else begin
            verdict_d.to_cpu = 1'b1;   // RULE8
         end
      end
   end

   // ----------------------------------------------------------------
   // verdict register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         verdict_q       <= '0;
         verdict_valid_q <= 1'b0;
      end else begin
         verdict_valid_q <= (state_q == VFH_EVAL);
         if (state_q == VFH_EVAL) begin
            verdict_q <= verdict_d;
         end
      end
   end

   assign verdict       = verdict_q;
   assign verdict_valid = verdict_valid_q;

   // ----------------------------------------------------------------
   // status counters
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         drop_cnt_q <= '0;
         cpu_cnt_q  <= '0;
      end else if (state_q == VFH_EVAL) begin
         if (verdict_d.drop) begin
            drop_cnt_q <= drop_cnt_q + VFH_CNT_ONE;
         end
         if (verdict_d.to_cpu) begin
            cpu_cnt_q <= cpu_cnt_q + VFH_CNT_ONE;
         end
      end
   end

endmodule : vfh_ctrl

// >>> dv/vfh_ctrl_assertions.sv
`timescale 1ns/1ps
module vfh_ctrl_checker
   import vfh_pkg::*;
(
   input wire logic                 clk,
   input wire logic                 arst_n,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 tbl_wr_en,
   input wire logic [11:0]          tbl_wr_vid,
   input wire logic                 tbl_wr_valid,
   input wire logic [VFH_PORTS-1:0] tbl_wr_untag,
   input wire logic                 frame_valid,
   input wire vfh_frame_type        frame_in,
   input wire logic                 verdict_valid,
   input wire vfh_verdict_type      verdict
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic            busy_q;
   logic [5:0]      ctl_q;
   wire  logic      take = frame_valid && !busy_q;
   // ---------------------------------------------------------
   // helper state
   // ---------------------------------------------------------
   // one evaluation cycle after each accepted frame
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) busy_q <= 1'b0;
      else busy_q <= take;
   end
   // shadow of the control word
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) ctl_q <= 6'h00;
      else if (psel && penable && pwrite && paddr == VFH_ADDR_CTRL) ctl_q <= pwdata[5:0];
   end
   // ---------------------------------------------------------
   // properties
   // ---------------------------------------------------------
   sequence s_out;
      ##2 verdict_valid;
   endsequence
   sequence s_fff;
      take && frame_in.has_tag && frame_in.vlan_identifier == VFH_VID_RESERVED;
   endsequence
   sequence s_bad_crc;
      take && frame_in.from_mgmt && !frame_in.crc_ok;
   endsequence
   sequence s_cpu;
      take && frame_in.from_cpu && frame_in.egress_directed;
   endsequence
   a_fff_drop: assert property (s_fff ##0 !ctl_q[3] |-> s_out ##0 verdict.drop)
      else $error("reserved id not dropped");
   a_fff_fwd: assert property (s_fff ##0 ctl_q[3] && frame_in.crc_ok |-> s_out ##0 !verdict.drop)
      else $error("reserved id dropped");
   a_crc_drop: assert property (s_bad_crc ##0 !ctl_q[4] |-> s_out ##0 verdict.drop)
      else $error("bad crc kept");
   a_crc_skip: assert property (s_bad_crc ##0 ctl_q[4] && !frame_in.has_tag |-> s_out ##0 !verdict.drop)
      else $error("crc checked while bypassed");
   a_trunk_skip: assert property (s_cpu ##0 ctl_q[1] |-> s_out ##0 !verdict.trunk_check)
      else $error("trunk check not bypassed");
   a_trunk_apply: assert property (s_cpu ##0 !ctl_q[1] |-> s_out ##0 verdict.trunk_check)
      else $error("trunk check missing");
   a_keep_tag: assert property (take && !frame_in.has_tag && !ctl_q[5] |-> s_out ##0 verdict.keep_tag_state == ctl_q[0])
      else $error("tag state preservation wrong");
   a_double_tag: assert property (take && ctl_q[5] |-> s_out ##0 !verdict.keep_tag_state)
      else $error("preservation in double tag");
   a_reserved_read: assert property (psel && penable && !pwrite && paddr == VFH_ADDR_CTRL |-> prdata == {26'h0, ctl_q})
      else $error("control readback wrong");
endmodule : vfh_ctrl_checker
bind vfh_ctrl vfh_ctrl_checker u_chk (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tbl_wr_en(tbl_wr_en),
   .tbl_wr_vid(tbl_wr_vid), .tbl_wr_valid(tbl_wr_valid), .tbl_wr_untag(tbl_wr_untag), .frame_valid(frame_valid),
   .frame_in(frame_in), .verdict_valid(verdict_valid), .verdict(verdict));

// >>> dv/vlan_frame_handling_controls_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end
module vlan_frame_handling_controls_bench
   import vfh_pkg::*;
;
   typedef struct packed {logic [5:0] ctl; vfh_frame_type frm; logic [3:0] exp;} vfh_row_type;
   logic            clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
   logic            tbl_wr_en, tbl_wr_valid, frame_valid, verdict_valid;
   logic [11:0]     paddr, tbl_wr_vid;
   logic [31:0]     pwdata, prdata, rd;
   logic [7:0]      tbl_wr_untag;
   logic [15:0]     nd, nc;
   vfh_frame_type   frame_in;
   vfh_verdict_type verdict;
   vfh_row_type     rows[11];
   int              miscompares = 0;
   int              comparisons = 0;
   // clock source
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   vfh_ctrl dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tbl_wr_en(tbl_wr_en),
      .tbl_wr_vid(tbl_wr_vid), .tbl_wr_valid(tbl_wr_valid), .tbl_wr_untag(tbl_wr_untag),
      .frame_valid(frame_valid), .frame_in(frame_in), .verdict_valid(verdict_valid), .verdict(verdict));
   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   function automatic vfh_row_type mk(logic [5:0] c, logic [11:0] v, logic t, logic m, logic u, logic k, logic [3:0] e);
      mk = '{c, '{v, t, !t, m, u, u, k, 3'h2}, e};
   endfunction : mk
   // one apb transfer, idle cycle after
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // one frame, verdict two edges later
   task automatic send(input vfh_row_type r);
      frame_in    <= r.frm;
      frame_valid <= 1'b1;
      @(posedge clk);
      frame_valid <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      `CHK("verdict_valid", 1'b1, verdict_valid)
   endtask : send
   task automatic summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // ---------------------------------------------------------
   // tests
   // ---------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {tbl_wr_en, tbl_wr_vid, tbl_wr_valid, tbl_wr_untag} = '0;
      frame_valid = 1'b0;
      frame_in = '0;
      // ctl, id, tagged, mgmt, cpu, crc ok, {drop, to_cpu, trunk, keep}
      rows[0]  = mk(6'h00, 12'h010, 1, 0, 0, 1, 4'h2);
      rows[1]  = mk(6'h00, 12'hFFF, 1, 0, 0, 1, 4'hA);
      rows[2]  = mk(6'h08, 12'hFFF, 1, 0, 0, 1, 4'h2);
      rows[3]  = mk(6'h04, 12'h020, 1, 0, 0, 1, 4'hA);
      rows[4]  = mk(6'h00, 12'h020, 1, 0, 0, 1, 4'h6);
      rows[5]  = mk(6'h00, 12'h000, 0, 1, 0, 0, 4'hA);
      rows[6]  = mk(6'h10, 12'h000, 0, 1, 0, 0, 4'h2);
      rows[7]  = mk(6'h00, 12'h000, 0, 0, 1, 1, 4'h2);
      rows[8]  = mk(6'h02, 12'h000, 0, 0, 1, 1, 4'h0);
      rows[9]  = mk(6'h01, 12'h000, 0, 0, 0, 1, 4'h3);
      rows[10] = mk(6'h21, 12'h000, 0, 0, 0, 1, 4'h2);
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, VFH_ADDR_CTRL, 32'h0);
      `CHK("ctrl_reset", 32'h0, rd)
      apb(1'b1, VFH_ADDR_CTRL, 32'hFFFFFFFF);
      `CHK("ctrl_wr_err", 1'b0, err)
      apb(1'b0, VFH_ADDR_CTRL, 32'h0);
      `CHK("ctrl_reserved", 32'h0000003F, rd)
      apb(1'b1, 12'h008, 32'h1);
      `CHK("unmapped_err", 1'b1, err)
      apb(1'b1, VFH_ADDR_STATUS, 32'hFFFF);
      `CHK("status_ro_err", 1'b1, err)
      $display("test registers done");
      // table: two live entries, one cleared entry
      for (int i = 0; i < 3; i++) begin
         tbl_wr_en    <= 1'b1;
         tbl_wr_vid   <= (i == 0) ? 12'h010 : (i == 1) ? 12'hFFF : 12'h020;
         tbl_wr_valid <= (i != 2);
         tbl_wr_untag <= 8'hA5;
         @(posedge clk);
      end
      tbl_wr_en <= 1'b0;
      nd = 16'h0;
      nc = 16'h0;
      foreach (rows[i]) begin
         apb(1'b1, VFH_ADDR_CTRL, {26'h0, rows[i].ctl});
         send(rows[i]);
         `CHK("verdict", rows[i].exp, {verdict.drop, verdict.to_cpu, verdict.trunk_check, verdict.keep_tag_state})
         if (i == 0) `CHK("untag_map", 8'hA5, verdict.untag_map)
         `CHK("dest_port", rows[i].frm.dest_port, verdict.dest_port)
         nd += rows[i].exp[3];
         nc += rows[i].exp[2];
         $display("test row %0d done", i);
      end
      apb(1'b0, VFH_ADDR_STATUS, 32'h0);
      `CHK("status", {nc, nd}, rd)
      // second request during evaluation is ignored
      frame_in    <= rows[7].frm;
      frame_valid <= 1'b1;
      repeat (2) @(posedge clk);
      frame_valid <= 1'b0;
      @(posedge clk);
      `CHK("first_verdict", 1'b1, verdict_valid)
      repeat (2) begin
         @(posedge clk);
         `CHK("no_second_verdict", 1'b0, verdict_valid)
      end
      $display("test overlap done");
      // mid-run reset clears control, counters and table
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("reset_valid", 1'b0, verdict_valid)
      arst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, VFH_ADDR_CTRL, 32'h0);
      `CHK("reset_ctrl", 32'h0, rd)
      apb(1'b0, VFH_ADDR_STATUS, 32'h0);
      `CHK("reset_status", 32'h0, rd)
      send(rows[0]);
      `CHK("reset_table", 4'h6, {verdict.drop, verdict.to_cpu, verdict.trunk_check, verdict.keep_tag_state})
      $display("test reset done");
      summarize();
   end
   // watchdog
   initial begin
      #200000;
      miscompares++;
      $display("watchdog expired");
      summarize();
   end
endmodule : vlan_frame_handling_controls_bench
